/* core/cbi_cfg.svh */
// Timing and layout constants for the cycle steal break interface.
// Assumes a 200 MHz core clock with processor timing sampled on it.
`ifndef CBI_CFG_SVH
`define CBI_CFG_SVH
`define CBI_WORD_W 12
`define CBI_PRIO 2
`define CBI_FIFO_DEPTH 4
`define CBI_CLK_PS 5000
`define CBI_ADDR_DLY_NS 50
// Longest time, rounded down
`define CBI_ADDR_DLY_CYC ((`CBI_ADDR_DLY_NS * 1000) / `CBI_CLK_PS)
`define CBI_INCR_WORD 12'h001
`define CBI_ADDR_RST 12'h000
`endif

/* core/cbi_pkg.sv */
// Types shared by the break interface modules.
// Assumes nothing beyond the constants header.
package cbi_pkg;
  typedef struct packed {
    logic int_strobe;
    logic time_state_2;
    logic time_state_3;
    logic time_state_4;
    logic time_pulse_1;
    logic time_pulse_2;
    logic time_pulse_3;
    logic time_pulse_4;
  } cbi_timing_s;
  typedef struct packed {
    logic break_req;
    logic add_to_memory;
    logic data_in;
    logic three_cycle;
  } cbi_req_s;
  typedef enum logic [1:0] {
    CYC_COUNT,
    CYC_ADDR,
    CYC_DATA
  } cbi_cyc_e;
endpackage : cbi_pkg

/* core/cbi_fifo.sv */
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module cbi_fifo #(
  parameter int W = 12,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : cbi_fifo
`default_nettype wire

/* core/cbi_arb.sv */
// Break priority network: one bus bit per priority, bit 0 highest.
// Assumes the bus reads high on bits that nobody grounds.
`timescale 1ns/1ps
`default_nettype none
module cbi_arb #(
  parameter int W = 12,
  parameter int PRIO = 2
) (
  input wire logic [W-1:0] bus_in,
  input wire logic window,
  input wire logic pending,
  output logic [W-1:0] drive_mask,
  output logic win
);
  logic [W-1:0] higher_ok;
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign higher_ok[i] = (i >= PRIO) || bus_in[i];
    assign drive_mask[i] = (i == PRIO) && window && pending;
  end
  assign win = &higher_ok;
endmodule : cbi_arb
`default_nettype wire

/* core/cbi_top.sv */
// Peripheral side cycle steal break interface for the backplane bus.
// Assumes processor time states and pulses arrive synchronous to clk.
// Overview of operation
// - Interrupt strobe edge with request asserts break in progress and address disable.
// - Ground own priority bit only in time state 4; check the higher priority bits.
// - On winning at time pulse 4 drive break address within 50 ns.
// - On winning also ground cycle flag and state/instruction disable.
// - Next time pulse 1 grounds the address and state load inhibit.
// - Same time pulse 1 sets add flip-flop and transfer direction lines.
// - Release control lines in the order they were asserted.
// - Input or add transfers hold the word on the bus through time state 2.
// - Output transfers capture memory data on a time pulse into a buffer.
// - Overflow line, low in time state 3, may be sampled at pulse 3.
// - Drop control at cycle end unless another word follows.
// - Three cycle mode runs word count, current address, then data cycles.
// - Three cycle mode loads break address from memory data in address cycle.
// - Arbitration repeats before each of the three cycles.
`timescale 1ns/1ps
`default_nettype none
`include "cbi_cfg.svh"
module cbi_top #(
  parameter int W = `CBI_WORD_W,
  parameter int PRIO = `CBI_PRIO,
  parameter int DEPTH = `CBI_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire cbi_pkg::cbi_timing_s timing,
  input wire logic [W-1:0] data_bus_in,
  output logic [W-1:0] data_bus_out,
  output logic [W-1:0] data_bus_oe,
  input wire logic [W-1:0] memory_data_in,
  output logic [W-1:0] memory_address_out,
  output logic memory_address_oe,
  input wire logic overflow_n,
  output logic break_in_progress_n,
  output logic processor_addr_disable_n,
  output logic dma_cycle_flag_n,
  output logic state_instr_disable_n,
  output logic addr_state_load_inhibit_n,
  output logic device_to_memory_path_n,
  output logic memory_read_direction_n,
  input wire cbi_pkg::cbi_req_s req,
  input wire logic [W-1:0] device_addr,
  input wire logic [W-1:0] device_word,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic overflow_seen
);
  localparam int ADDR_DLY = `CBI_ADDR_DLY_CYC;
  // Edge detectors on the time pulses and strobe
  logic strobe_q;
  logic pulse1_q;
  logic pulse2_q;
  logic pulse3_q;
  logic pulse4_q;
  logic strobe_edge;
  logic pulse1_edge;
  logic pulse2_edge;
  logic pulse3_edge;
  logic pulse4_edge;
  // New break request, address control, load control
  logic nbr;
  logic addr_cont;
  logic malc;
  logic add_to_memory_ff;
  logic out_ff;
  logic in_ff;
  logic [W-1:0] break_address;
  cbi_pkg::cbi_cyc_e cyc;
  cbi_pkg::cbi_cyc_e next_cyc;
  logic [W-1:0] prio_mask;
  logic win;
  logic fifo_ready;
  logic push;
  logic req_ok;
  logic more;
  logic writes_bus;
  logic [W-1:0] bus_word;

  assign strobe_edge = timing.int_strobe && !strobe_q;
  assign pulse1_edge = timing.time_pulse_1 && !pulse1_q;
  assign pulse2_edge = timing.time_pulse_2 && !pulse2_q;
  assign pulse3_edge = timing.time_pulse_3 && !pulse3_q;
  assign pulse4_edge = timing.time_pulse_4 && !pulse4_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_q <= 1'b0;
      pulse1_q <= 1'b0;
      pulse2_q <= 1'b0;
      pulse3_q <= 1'b0;
      pulse4_q <= 1'b0;
    end else begin
      strobe_q <= timing.int_strobe;
      pulse1_q <= timing.time_pulse_1;
      pulse2_q <= timing.time_pulse_2;
      pulse3_q <= timing.time_pulse_3;
      pulse4_q <= timing.time_pulse_4;
    end
  end

  // A memory to device request waits while the buffer is full,
  // so the device's drain rate throttles the break rate.
  assign req_ok = req.break_req && (req.data_in || req.add_to_memory || fifo_ready);

  always_comb begin
    next_cyc = cyc;
    case (cyc)
      cbi_pkg::CYC_COUNT: next_cyc = cbi_pkg::CYC_ADDR;
      cbi_pkg::CYC_ADDR: next_cyc = cbi_pkg::CYC_DATA;
      cbi_pkg::CYC_DATA: next_cyc = cbi_pkg::CYC_COUNT;
      default: next_cyc = cbi_pkg::CYC_COUNT;
    endcase
  end

  // Mid-sequence of a three cycle break the request is implied
  assign more = malc && req.three_cycle && (cyc != cbi_pkg::CYC_DATA);

  // New break flip-flop follows the strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nbr <= 1'b0;
    end else if (strobe_edge) begin
      nbr <= req_ok || more;
    end
  end

  // Major state sequencer, advanced at the end of each active cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc <= cbi_pkg::CYC_COUNT;
    end else if (strobe_edge && malc) begin
      cyc <= req.three_cycle ? next_cyc : cbi_pkg::CYC_DATA;
    end else if (!nbr && !addr_cont && !malc) begin
      cyc <= req.three_cycle ? cbi_pkg::CYC_COUNT : cbi_pkg::CYC_DATA;
    end
  end

  // Address control: priority re-checked at every pulse 4
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_cont <= 1'b0;
    end else if (pulse4_edge) begin
      addr_cont <= nbr && win;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      break_address <= `CBI_ADDR_RST;
    end else if (pulse4_edge && nbr && win && cyc != cbi_pkg::CYC_DATA) begin
      // Word count lives at the device address, current address after it
      break_address <= (cyc == cbi_pkg::CYC_ADDR) ? W'(device_addr + 1'b1) : device_addr;
    end else if (pulse4_edge && nbr && win && !req.three_cycle) begin
      break_address <= device_addr;
    end else if (pulse2_edge && malc && cyc == cbi_pkg::CYC_ADDR) begin
      break_address <= memory_data_in;
    end
  end

  // Load control and transfer path, latched at pulse 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      malc <= 1'b0;
      add_to_memory_ff <= 1'b0;
      out_ff <= 1'b0;
      in_ff <= 1'b0;
    end else if (pulse1_edge) begin
      malc <= addr_cont;
      if (addr_cont && cyc != cbi_pkg::CYC_DATA) begin
        // Count and address words are incremented in place
        add_to_memory_ff <= 1'b1;
        out_ff <= 1'b0;
        in_ff <= 1'b0;
      end else if (addr_cont) begin
        add_to_memory_ff <= req.add_to_memory;
        out_ff <= !req.data_in && !req.add_to_memory;
        in_ff <= req.data_in && !req.add_to_memory;
      end else begin
        add_to_memory_ff <= 1'b0;
        out_ff <= 1'b0;
        in_ff <= 1'b0;
      end
    end
  end

  // Overflow sampled at pulse 3 inside time state 3
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overflow_seen <= 1'b0;
    end else if (pulse3_edge && timing.time_state_3 && malc && add_to_memory_ff) begin
      overflow_seen <= !overflow_n;
    end
  end

  cbi_arb #(
    .W(W),
    .PRIO(PRIO)
  ) cbi_arb_inst (
    .bus_in(data_bus_in),
    .window(timing.time_state_4),
    .pending(nbr),
    .drive_mask(prio_mask),
    .win(win)
  );

  assign writes_bus = malc && (add_to_memory_ff || in_ff) && timing.time_state_2;
  assign bus_word = (cyc == cbi_pkg::CYC_DATA) ? device_word : `CBI_INCR_WORD;

  // Registered bus drive; one clock of lag is small against a time state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_bus_out <= '0;
      data_bus_oe <= '0;
    end else if (writes_bus) begin
      data_bus_out <= bus_word;
      data_bus_oe <= '1;
    end else begin
      data_bus_out <= '0;
      data_bus_oe <= prio_mask;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memory_address_out <= '0;
    end else begin
      memory_address_out <= break_address;
    end
  end

  assign memory_address_oe = addr_cont;
  assign break_in_progress_n = !nbr;
  assign processor_addr_disable_n = !nbr;
  assign dma_cycle_flag_n = !addr_cont;
  assign state_instr_disable_n = !addr_cont;
  assign addr_state_load_inhibit_n = !malc;
  assign device_to_memory_path_n = !(malc && (in_ff || add_to_memory_ff));
  assign memory_read_direction_n = !(malc && out_ff);

  assign push = pulse3_edge && malc && out_ff && cyc == cbi_pkg::CYC_DATA;

  cbi_fifo #(
    .W(W),
    .D(DEPTH)
  ) cbi_fifo_inst (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(memory_data_in),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  chk_strobe_sets_bk: assert property (@(posedge clk) disable iff (rst)
    (strobe_edge && req_ok) |=> (!break_in_progress_n && !processor_addr_disable_n))
    else $error("break in progress not asserted after strobe");

  chk_prio_in_window: assert property (@(posedge clk) disable iff (rst)
    (data_bus_oe[PRIO] && !$past(writes_bus)) |-> $past(timing.time_state_4))
    else $error("priority bit driven outside time state 4");

  chk_address_in_time: assert property (@(posedge clk) disable iff (rst)
    (pulse4_edge && nbr && win) |-> ##[1:ADDR_DLY] memory_address_oe)
    else $error("break address not on lines in time");

  chk_dma_flags_win: assert property (@(posedge clk) disable iff (rst)
    (pulse4_edge && nbr && win) |=> (!dma_cycle_flag_n && !state_instr_disable_n))
    else $error("cycle flag or state disable missing after win");

  chk_load_inhibit: assert property (@(posedge clk) disable iff (rst)
    (pulse1_edge && addr_cont) |=> !addr_state_load_inhibit_n)
    else $error("load inhibit not grounded at pulse 1");

  chk_path_select: assert property (@(posedge clk) disable iff (rst)
    (pulse1_edge && addr_cont && cyc == cbi_pkg::CYC_DATA && !req.data_in && !req.add_to_memory)
    |=> (!memory_read_direction_n && device_to_memory_path_n))
    else $error("read direction not set for output transfer");

  chk_release_order: assert property (@(posedge clk) disable iff (rst)
    $fell(addr_cont) |-> break_in_progress_n)
    else $error("address control released before break in progress");

  chk_word_in_ts2: assert property (@(posedge clk) disable iff (rst)
    writes_bus |=> (data_bus_oe == '1 && data_bus_out == $past(bus_word)))
    else $error("input word missing in time state 2");

  chk_output_capture: assert property (@(posedge clk) disable iff (rst)
    push |=> (out_valid && break_address == $past(break_address)))
    else $error("memory data not captured into buffer");

  chk_overflow_sample: assert property (@(posedge clk) disable iff (rst)
    (pulse3_edge && timing.time_state_3 && malc && add_to_memory_ff && !overflow_n) |=> overflow_seen)
    else $error("overflow not sampled at pulse 3");

  chk_end_release: assert property (@(posedge clk) disable iff (rst)
    (strobe_edge && !req.break_req && !more) |=> break_in_progress_n)
    else $error("break control kept without a further word");

  chk_three_seq: assert property (@(posedge clk) disable iff (rst)
    (strobe_edge && malc && req.three_cycle && cyc == cbi_pkg::CYC_COUNT) |=> cyc == cbi_pkg::CYC_ADDR)
    else $error("word count cycle not followed by address cycle");

  chk_ca_load: assert property (@(posedge clk) disable iff (rst)
    (pulse2_edge && malc && cyc == cbi_pkg::CYC_ADDR) |=> break_address == $past(memory_data_in))
    else $error("break address not loaded from memory data");

  chk_rearbitrate: assert property (@(posedge clk) disable iff (rst)
    (pulse4_edge && nbr && !win) |=> dma_cycle_flag_n)
    else $error("cycle taken without winning arbitration");

  chk_pulse_sync: assert property (@(posedge clk) disable iff (rst)
    $changed(addr_cont) |-> $past(pulse4_edge))
    else $error("address control changed off pulse 4");
endmodule : cbi_top
`default_nettype wire

/* testbench/cbi_proc_model.sv */
// Processor and core memory model on the far side of the break interface.
// Assumes the bench clock and reset; the bench presets memory through hierarchy.
`timescale 1ns/1ps
`default_nettype none
module cbi_proc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic hi_prio,
  input wire logic [11:0] data_bus_out,
  input wire logic [11:0] data_bus_oe,
  input wire logic [11:0] memory_address_out,
  input wire logic memory_address_oe,
  input wire logic device_to_memory_path_n,
  output var cbi_pkg::cbi_timing_s timing,
  output logic [11:0] data_bus_in,
  output logic [11:0] memory_data_in,
  output logic overflow_n
);
  logic [11:0] mem [0:4095];
  logic [3:0] ph;
  logic [11:0] ad;
  logic [11:0] wrd;
  logic [11:0] lastv;
  logic [12:0] sum;
  logic modify;
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 12'h000;
  end
  // Pulses close each time state; the strobe rides with the third pulse
  assign timing = {ph == 4'h8, ph >= 4'h1 && ph <= 4'h4, ph >= 4'h5 && ph <= 4'h8, ph >= 4'h9 && ph <= 4'hc,
                   ph == 4'h0, ph == 4'h4, ph == 4'h8, ph == 4'hc};
  // Pull-ups: undriven bits read high; a rival device may ground bit 0
  assign data_bus_in = (data_bus_out | ~data_bus_oe) & ~{11'h000, hi_prio & timing.time_state_4};
  // Unaddressed lines show the inverse of the last word, not a stale copy
  assign memory_data_in = memory_address_oe ? mem[memory_address_out] : ~lastv;
  assign sum = {1'b0, mem[ad]} + {1'b0, wrd};
  assign overflow_n = !(timing.time_state_3 && modify && sum[12]);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= 4'h0;
      lastv <= 12'h000;
    end else begin
      ph <= ph + 4'h1;
      if (memory_address_oe) lastv <= memory_data_in;
    end
  end
  // Plain always so the bench may also write the array
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      modify <= 1'b0;
    end else if (ph == 4'h4) begin
      modify <= !device_to_memory_path_n;
      ad <= memory_address_out;
      wrd <= data_bus_in;
    end else if (ph == 4'h8 && modify) begin
      mem[ad] <= sum[11:0];
    end
  end
endmodule : cbi_proc_model
`default_nettype wire

/* testbench/cycle_steal_break_interface_test.sv */
// Self-checking bench for the cycle steal break interface.
// Assumes the processor model supplies timing, bus pull-ups and memory.
`timescale 1ns/1ps
`default_nettype none
module cycle_steal_break_interface_test;
  localparam int PRIO = 2;
  localparam int STROBE = 7;
  localparam int PULSE1 = 3;
  localparam int PULSE4 = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hi_prio = 1'b0;
  logic out_ready = 1'b0;
  logic [11:0] device_addr = 12'h000;
  logic [11:0] device_word = 12'h000;
  cbi_pkg::cbi_req_s req = '0;
  cbi_pkg::cbi_timing_s timing;
  logic [11:0] data_bus_in, data_bus_out, data_bus_oe, memory_data_in, memory_address_out, out_data;
  logic memory_address_oe, overflow_n, bip_n, pad_n, dma_n, sid_n, malc_n, path_n, dir_n, out_valid, overflow_seen;
  int mismatches = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  cbi_top #(.PRIO(PRIO)) cbi_top_inst (
    .clk(clk), .rst(rst), .timing(timing), .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .memory_data_in(memory_data_in), .memory_address_out(memory_address_out),
    .memory_address_oe(memory_address_oe), .overflow_n(overflow_n), .break_in_progress_n(bip_n),
    .processor_addr_disable_n(pad_n), .dma_cycle_flag_n(dma_n), .state_instr_disable_n(sid_n),
    .addr_state_load_inhibit_n(malc_n), .device_to_memory_path_n(path_n), .memory_read_direction_n(dir_n),
    .req(req), .device_addr(device_addr), .device_word(device_word), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready), .overflow_seen(overflow_seen));
  cbi_proc_model cbi_proc_model_inst (
    .clk(clk), .rst(rst), .hi_prio(hi_prio), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .memory_address_out(memory_address_out), .memory_address_oe(memory_address_oe),
    .device_to_memory_path_n(path_n), .timing(timing), .data_bus_in(data_bus_in),
    .memory_data_in(memory_data_in), .overflow_n(overflow_n));
  task automatic chk_b(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : chk_b
  task automatic chk_w(input string n, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk_w
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Returns one clock after the design has reacted to the chosen pulse
  task automatic sync(input int b);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (timing[b] !== 1'b1 && n < 40);
    if (n >= 40) chk_b("pulse", 1'b1, 1'b0);
    repeat (2) @(posedge clk);
    #1;
  endtask : sync
  task automatic set_req(input logic b, input logic a, input logic d, input logic t, input logic [11:0] ad,
                         input logic [11:0] w);
    @(posedge clk);
    req <= '{break_req: b, add_to_memory: a, data_in: d, three_cycle: t};
    device_addr <= ad;
    device_word <= w;
    #1;
  endtask : set_req
  task automatic took(input logic e);
    sync(STROBE);
    chk_b("bip", e, bip_n);
    chk_b("cpd", e, pad_n);
  endtask : took
  // Follows took: arbitration, address, path lines, then the bus word
  task automatic break_cycle(input logic [11:0] a, input logic [11:0] w, input logic outdir);
    @(posedge clk);
    #1;
    chk_w("prio_oe", 12'h001 << PRIO, data_bus_oe);
    chk_b("prio_bit", 1'b0, data_bus_out[PRIO]);
    sync(PULSE4);
    chk_b("addr_oe", 1'b1, memory_address_oe);
    chk_w("addr", a, memory_address_out);
    chk_b("dma", 1'b0, dma_n);
    chk_b("sid", 1'b0, sid_n);
    sync(PULSE1);
    chk_b("malc", 1'b0, malc_n);
    chk_b("path", outdir, path_n);
    chk_b("dir", !outdir, dir_n);
    @(posedge clk);
    #1;
    if (!outdir) chk_w("word", w, data_bus_in);
  endtask : break_cycle
  task automatic t_input();
    set_req(1, 0, 1, 0, 12'h010, 12'h5a3);
    took(1'b0);
    break_cycle(12'h010, 12'h5a3, 1'b0);
    set_req(0, 0, 1, 0, 12'h010, 12'h5a3);
    sync(STROBE);
    chk_b("bip_off", 1'b1, bip_n);
    chk_b("dma_on", 1'b0, dma_n);
    sync(PULSE4);
    chk_b("dma_off", 1'b1, dma_n);
    chk_b("malc_on", 1'b0, malc_n);
    sync(PULSE1);
    chk_b("malc_off", 1'b1, malc_n);
    chk_w("mem", 12'h5a3, cbi_proc_model_inst.mem[12'h010]);
  endtask : t_input
  // Device drain stalls while four back-to-back reads fill the buffer
  task automatic t_output();
    for (int i = 0; i < 4; i++) cbi_proc_model_inst.mem[12'h020 + i] = 12'h3c0 + 12'(i);
    set_req(1, 0, 0, 0, 12'h020, 12'h000);
    took(1'b0);
    for (int i = 0; i < 4; i++) begin
      break_cycle(12'h020 + 12'(i), 12'h000, 1'b1);
      set_req(i < 3, 0, 0, 0, 12'h021 + 12'(i), 12'h000);
      if (i < 3) took(1'b0);
    end
    took(1'b1);
    set_req(1, 0, 0, 0, 12'h030, 12'h000);
    took(1'b1);
    set_req(0, 0, 0, 0, 12'h030, 12'h000);
    @(posedge clk);
    out_ready <= 1'b1;
    #1;
    for (int i = 0; i < 4; i++) begin
      chk_b("valid", 1'b1, out_valid);
      chk_w("fifo", 12'h3c0 + 12'(i), out_data);
      @(posedge clk);
      #1;
    end
    chk_b("empty", 1'b0, out_valid);
    @(posedge clk);
    out_ready <= 1'b0;
  endtask : t_output
  // Loses once to a rival, then wins and overflows memory
  task automatic t_add();
    cbi_proc_model_inst.mem[12'h030] = 12'hfff;
    @(posedge clk);
    hi_prio <= 1'b1;
    set_req(1, 1, 0, 0, 12'h030, 12'h002);
    took(1'b0);
    sync(PULSE4);
    chk_b("lost", 1'b1, dma_n);
    chk_b("held", 1'b0, bip_n);
    @(posedge clk);
    hi_prio <= 1'b0;
    took(1'b0);
    break_cycle(12'h030, 12'h002, 1'b0);
    set_req(0, 0, 0, 0, 12'h030, 12'h002);
    took(1'b1);
    chk_b("ovf", 1'b1, overflow_seen);
    chk_w("sum", 12'h001, cbi_proc_model_inst.mem[12'h030]);
  endtask : t_add
  task automatic t_three();
    cbi_proc_model_inst.mem[12'h040] = 12'hffd;
    cbi_proc_model_inst.mem[12'h041] = 12'h04f;
    set_req(1, 0, 1, 1, 12'h040, 12'h777);
    took(1'b0);
    break_cycle(12'h040, 12'h001, 1'b0);
    took(1'b0);
    break_cycle(12'h041, 12'h001, 1'b0);
    took(1'b0);
    break_cycle(12'h04f, 12'h777, 1'b0);
    set_req(0, 0, 1, 1, 12'h040, 12'h777);
    took(1'b1);
    chk_w("wc", 12'hffe, cbi_proc_model_inst.mem[12'h040]);
    chk_w("ca", 12'h050, cbi_proc_model_inst.mem[12'h041]);
    chk_w("data", 12'h777, cbi_proc_model_inst.mem[12'h04f]);
  endtask : t_three
  initial begin
    #50000;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    chk_b("rst_bip", 1'b1, bip_n);
    chk_b("rst_dma", 1'b1, dma_n);
    chk_w("rst_oe", 12'h000, data_bus_oe);
    rst <= 1'b0;
    t_input();
    t_output();
    t_add();
    t_three();
    end_sim();
  end
endmodule : cycle_steal_break_interface_test
`default_nettype wire
